// >>> core/adcc_params.svh
/*
  Constants of the conversion control block: register offsets, field positions,
  reset values and timing counts. Assumes a 125 MHz APB clock.
*/
`ifndef ADCC_PARAMS_SVH
`define ADCC_PARAMS_SVH

// register byte offsets
`define ADCC_OFF_SC1 12'h000
`define ADCC_OFF_SC2 12'h004
`define ADCC_OFF_RES_HI 12'h008
`define ADCC_OFF_RES_LO 12'h00C
`define ADCC_OFF_CV_HI 12'h010
`define ADCC_OFF_CV_LO 12'h014
`define ADCC_OFF_CFG 12'h018
`define ADCC_OFF_IRQ_STAT 12'h01C
`define ADCC_OFF_IRQ_MASK 12'h020

// status_control_one fields
`define ADCC_SC1_DONE 7
`define ADCC_SC1_IEN 6
`define ADCC_SC1_CONT 5
`define ADCC_SC1_CH_MSB 4
`define ADCC_CH_OFF 5'h1F
// status_control_two fields
`define ADCC_SC2_ACTIVE 7
`define ADCC_SC2_CMP_EN 5
`define ADCC_SC2_CMP_GT 4
// converter_config fields
`define ADCC_CFG_LP 7
`define ADCC_CFG_LSMP 4
`define ADCC_CFG_MODE10 3
`define ADCC_CFG_ASYNC 0
// interrupt status bits
`define ADCC_IRQ_DONE 0
`define ADCC_IRQ_DISCARD 1
`define ADCC_IRQ_ABORT 2

// reset values
`define ADCC_SC1_RST 8'h1F
`define ADCC_REG_RST 8'h00
`define ADCC_RES_RST 10'h000

// conversion clock divider in bus clocks, normal and low power
`define ADCC_DIV_NORM 8'h04
`define ADCC_DIV_LP 8'h08
// sample time in conversion clock ticks
`define ADCC_SMP_SHORT 5'h04
`define ADCC_SMP_LONG 5'h14

`endif

// >>> core/adcc_pkg.sv
/*
  Types of the conversion control block.
  Assumes adcc_params.svh provides the numeric constants.
*/
package adcc_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_CONVERT
  } adcc_state_e;

  typedef struct packed {
    logic low_power;
    logic long_sample;
    logic mode10;
    logic clk_async;
  } adcc_cfg_s;

endpackage

// >>> core/adcc_sar.sv
/*
  Successive approximation sequencer: drives the trial code to the DAC and
  reads the comparator once per conversion clock tick.
  Assumes cmp_in is valid for the code presented before each tick.
*/
`timescale 1ns/1ps
module adcc_sar (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // control
  input wire logic start,
  input wire logic stop,
  input wire logic tick,
  input wire logic mode10,
  // analog side
  input wire logic cmp_in,
  output logic [9:0] code_q,
  // result
  output logic done_q
);
  logic [3:0] idx_q;
  logic busy_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_q <= 10'h000;
      idx_q <= 4'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (ce) begin
      done_q <= 1'b0;
      if (stop) begin
        busy_q <= 1'b0;
      end else if (start) begin
        busy_q <= 1'b1;
        idx_q <= mode10 ? 4'h9 : 4'h7;
        code_q <= mode10 ? 10'h200 : 10'h080;
      end else if (busy_q && tick) begin
        // a low comparator means the trial overshot the input
        if (!cmp_in) begin
          code_q[idx_q] <= 1'b0;
        end
        if (idx_q == 4'h0) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          code_q[idx_q - 4'h1] <= 1'b1;
          idx_q <= idx_q - 4'h1;
        end
      end
    end
  end
endmodule

// >>> core/adcc_top.sv
/*
  Conversion control for a successive approximation converter: APB registers,
  sample and approximation sequencing, result transfer with read blocking,
  aborts, and a masked interrupt.
  Assumes an external DAC and comparator, and a stop request from the system.
*/
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`include "adcc_params.svh"

module adcc_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog side
  input wire logic cmp_in,
  output logic [9:0] dac_code,
  output logic sample_on,
  output logic async_clk_en,
  output logic low_power,
  // system
  input wire logic stop_req,
  output logic irq
);
  adcc_pkg::adcc_state_e state_q;
  adcc_pkg::adcc_cfg_s cfg;

  logic [7:0] sc1_q;
  logic [7:0] sc2_q;
  logic [7:0] cfg_q;
  logic [7:0] cvh_q;
  logic [7:0] cvl_q;
  logic [9:0] result_q;
  logic [2:0] irq_stat_q;
  logic [2:0] irq_mask_q;
  logic hi_read_q;
  logic [7:0] div_q;
  logic [4:0] smp_q;
  logic [31:0] rdata_d;
  logic valid_d;
  logic [9:0] code;
  logic sar_done;

  // apb decode
  logic setup_acc;
  logic fin;
  logic wr;
  logic rd;
  assign setup_acc = psel && penable && !pready;
  assign fin = psel && penable && pready;
  assign wr = fin && pwrite && !pslverr;
  assign rd = fin && !pwrite && !pslverr;

  logic wr_sc1;
  logic wr_other;
  logic rd_hi;
  logic rd_lo;
  logic rd_stat;
  assign wr_sc1 = wr && paddr == `ADCC_OFF_SC1;
  assign wr_other = wr && (paddr == `ADCC_OFF_SC2 || paddr == `ADCC_OFF_CFG ||
                           paddr == `ADCC_OFF_CV_HI || paddr == `ADCC_OFF_CV_LO);
  assign rd_hi = rd && paddr == `ADCC_OFF_RES_HI;
  assign rd_lo = rd && paddr == `ADCC_OFF_RES_LO;
  assign rd_stat = rd && paddr == `ADCC_OFF_IRQ_STAT;

  assign cfg = '{low_power: cfg_q[`ADCC_CFG_LP], long_sample: cfg_q[`ADCC_CFG_LSMP],
                 mode10: cfg_q[`ADCC_CFG_MODE10], clk_async: cfg_q[`ADCC_CFG_ASYNC]};

  // abort and start conditions
  logic stop_abort;
  logic start_new;
  logic abort;
  assign stop_abort = stop_req && !cfg.clk_async;
  assign start_new = wr_sc1 && pwdata[`ADCC_SC1_CH_MSB:0] != `ADCC_CH_OFF;
  assign abort = wr_sc1 || wr_other || stop_abort;

  // conversion clock tick; low power halves the conversion clock rate
  logic tick;
  assign tick = div_q == 8'h00;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 8'h00;
    end else if (ce) begin
      if (state_q == adcc_pkg::ST_IDLE || tick) begin
        div_q <= (cfg.low_power ? `ADCC_DIV_LP : `ADCC_DIV_NORM) - 8'h01;
      end else begin
        div_q <= div_q - 8'h01;
      end
    end
  end

  // end of approximation: decide between transfer, discard and stop
  logic [9:0] cv;
  logic cmp_en;
  logic cmp_ok;
  logic blocked;
  logic cont;
  logic transfer;
  logic restart;
  assign cv = cfg.mode10 ? {cvh_q[1:0], cvl_q} : {2'b00, cvl_q};
  assign cmp_en = sc2_q[`ADCC_SC2_CMP_EN];
  assign cmp_ok = !cmp_en || (sc2_q[`ADCC_SC2_CMP_GT] ? code >= cv : code < cv);
  // a low-byte read in the same cycle releases the block first
  assign blocked = cfg.mode10 && hi_read_q && !rd_lo;
  assign cont = sc1_q[`ADCC_SC1_CONT];
  assign transfer = sar_done && cmp_ok && !blocked;
  always_comb begin
    restart = 1'b0;
    if (sar_done) begin
      if (!cmp_ok) begin
        restart = cont;
      end else if (blocked) begin
        restart = 1'b1;
      end else begin
        restart = cont;
      end
    end
  end

  // sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= adcc_pkg::ST_IDLE;
      smp_q <= 5'h00;
    end else if (ce) begin
      if (abort) begin
        state_q <= start_new && !stop_abort ? adcc_pkg::ST_SAMPLE : adcc_pkg::ST_IDLE;
        smp_q <= cfg.long_sample ? `ADCC_SMP_LONG : `ADCC_SMP_SHORT;
      end else begin
        case (state_q)
          adcc_pkg::ST_IDLE: begin
            smp_q <= cfg.long_sample ? `ADCC_SMP_LONG : `ADCC_SMP_SHORT;
          end
          adcc_pkg::ST_SAMPLE: begin
            if (tick) begin
              if (smp_q == 5'h01) begin
                state_q <= adcc_pkg::ST_CONVERT;
              end else begin
                smp_q <= smp_q - 5'h01;
              end
            end
          end
          adcc_pkg::ST_CONVERT: begin
            if (sar_done) begin
              state_q <= restart ? adcc_pkg::ST_SAMPLE : adcc_pkg::ST_IDLE;
              smp_q <= cfg.long_sample ? `ADCC_SMP_LONG : `ADCC_SMP_SHORT;
            end
          end
          default: begin
            state_q <= adcc_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  logic enter_conv;
  assign enter_conv = !abort && state_q == adcc_pkg::ST_SAMPLE && tick && smp_q == 5'h01;

  adcc_sar u_sar (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .start(enter_conv),
    .stop(abort),
    .tick(tick),
    .mode10(cfg.mode10),
    .cmp_in(cmp_in),
    .code_q(code),
    .done_q(sar_done)
  );

  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sc1_q <= `ADCC_SC1_RST;
      sc2_q <= `ADCC_REG_RST;
      cfg_q <= `ADCC_REG_RST;
      cvh_q <= `ADCC_REG_RST;
      cvl_q <= `ADCC_REG_RST;
      irq_mask_q <= 3'h0;
    end else if (ce) begin
      if (wr_sc1) begin
        sc1_q[`ADCC_SC1_IEN:0] <= pwdata[`ADCC_SC1_IEN:0];
      end
      if (transfer) begin
        sc1_q[`ADCC_SC1_DONE] <= 1'b1;
      end else if (wr_sc1 || rd_lo) begin
        sc1_q[`ADCC_SC1_DONE] <= 1'b0;
      end
      if (wr && paddr == `ADCC_OFF_SC2) begin
        sc2_q <= pwdata[7:0];
      end
      if (wr && paddr == `ADCC_OFF_CFG) begin
        cfg_q <= pwdata[7:0];
      end
      if (wr && paddr == `ADCC_OFF_CV_HI) begin
        cvh_q <= pwdata[7:0];
      end
      if (wr && paddr == `ADCC_OFF_CV_LO) begin
        cvl_q <= pwdata[7:0];
      end
      if (wr && paddr == `ADCC_OFF_IRQ_MASK) begin
        irq_mask_q <= pwdata[2:0];
      end
    end
  end

  // result pair; aborts never touch it, only reset clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q <= `ADCC_RES_RST;
    end else if (ce && transfer) begin
      result_q <= code;
    end
  end

  // read blocking: high byte opens it, low byte closes it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_read_q <= 1'b0;
    end else if (ce) begin
      if (rd_lo || !cfg.mode10) begin
        hi_read_q <= 1'b0;
      end else if (rd_hi) begin
        hi_read_q <= 1'b1;
      end
    end
  end

  // sticky events, cleared by reading the status; a new event wins
  logic [2:0] ev;
  assign ev[`ADCC_IRQ_DONE] = transfer && sc1_q[`ADCC_SC1_IEN];
  assign ev[`ADCC_IRQ_DISCARD] = sar_done && cmp_ok && blocked;
  assign ev[`ADCC_IRQ_ABORT] = abort && state_q != adcc_pkg::ST_IDLE;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= 3'h0;
      irq <= 1'b0;
    end else if (ce) begin
      irq_stat_q <= (rd_stat ? 3'h0 : irq_stat_q) | ev;
      irq <= |(((rd_stat ? 3'h0 : irq_stat_q) | ev) & irq_mask_q);
    end
  end

  // read mux
  always_comb begin
    rdata_d = 32'h0000_0000;
    valid_d = 1'b1;
    case (paddr)
      `ADCC_OFF_SC1: rdata_d[7:0] = sc1_q;
      `ADCC_OFF_SC2: rdata_d[7:0] = {state_q != adcc_pkg::ST_IDLE, sc2_q[6:0]};
      `ADCC_OFF_RES_HI: rdata_d[7:0] = cfg.mode10 ? {6'h00, result_q[9:8]} : 8'h00;
      `ADCC_OFF_RES_LO: rdata_d[7:0] = result_q[7:0];
      `ADCC_OFF_CV_HI: rdata_d[7:0] = cvh_q;
      `ADCC_OFF_CV_LO: rdata_d[7:0] = cvl_q;
      `ADCC_OFF_CFG: rdata_d[7:0] = cfg_q;
      `ADCC_OFF_IRQ_STAT: rdata_d[2:0] = irq_stat_q;
      `ADCC_OFF_IRQ_MASK: rdata_d[2:0] = irq_mask_q;
      default: valid_d = 1'b0;
    endcase
  end

  // one wait state keeps every bus output on a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      pready <= setup_acc;
      pslverr <= setup_acc && !valid_d;
      if (setup_acc && !pwrite) begin
        prdata <= rdata_d;
      end
    end
  end

  // analog side pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_on <= 1'b0;
      async_clk_en <= 1'b0;
      low_power <= 1'b0;
      dac_code <= 10'h000;
    end else if (ce) begin
      sample_on <= state_q == adcc_pkg::ST_SAMPLE && !abort;
      async_clk_en <= cfg.clk_async && state_q != adcc_pkg::ST_IDLE;
      low_power <= cfg.low_power;
      // 8-bit trials weigh the top eight DAC bits so the result spans full scale
      dac_code <= cfg.mode10 ? code : {code[7:0], 2'b00};
    end
  end
endmodule

// >>> tb/adc_conversion_control_test.sv
/*
  Self-checking bench: random conversions, blocking, compare stop, aborts,
  async clock gating and reset. Assumes the checker and model are compiled first.
*/
`timescale 1ns/1ps
module adc_conversion_control_test;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, cmp_in, sample_on;
  logic async_clk_en, low_power, stop_req, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, seed;
  logic [9:0] dac_code, vin, va;
  logic [7:0] cfg;
  int n_errors, checks_done, k;
  adcc_top DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmp_in(cmp_in),
    .dac_code(dac_code), .sample_on(sample_on), .async_clk_en(async_clk_en), .low_power(low_power),
    .stop_req(stop_req), .irq(irq));
  adcc_analog_model u_ana (.pclk(pclk), .presetn(presetn), .dac_code(dac_code), .vin(vin), .cmp_in(cmp_in));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    repeat (60000) @(posedge pclk);
    n_errors++;
    summarize();
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [31:0] exp_lo(input logic [9:0] v, input logic m10);
    return m10 ? {24'h0, v[7:0]} : {24'h0, v[9:2]};
  endfunction
  function automatic logic [31:0] exp_hi(input logic [9:0] v, input logic m10);
    return m10 ? {30'h0, v[9:8]} : 32'h0;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(t, 32'h2);
  endtask
  task automatic wait_done();
    for (int t = 0; t < 300; t++) begin
      apb(0, 12'h000, 0);
      if (r[7] === 1'b1) break;
    end
    chk1(r[7], 1'b1);
  endtask
  task automatic conv(input logic [7:0] c, input logic [9:0] v);
    vin <= v;
    cfg = c;
    apb(1, 12'h018, {24'h0, c});
    apb(1, 12'h000, 32'h45);
    wait_done();
  endtask
  task automatic endt(input int n);
    $display("test %0d finished", n);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    {psel, penable, pwrite, stop_req, presetn} = 5'h00;
    ce = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0;
    vin = 10'h000;
    seed = 32'hC26372CA;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h000, 0);
    chk(r, 32'h1F);
    apb(0, 12'h00C, 0);
    chk(r, 32'h0);
    apb(0, 12'h024, 0);
    chk({r[30:0], err}, 32'h1);
    endt(0);
    // random mode, sample length, power and mask
    for (k = 0; k < 4; k++) begin
      seed = xs(seed);
      apb(1, 12'h020, {29'h0, {3{seed[13]}}});
      conv({seed[12], 2'b00, seed[11], seed[10], 3'b000}, seed[25:16]);
      repeat (2) @(posedge pclk);
      chk1(low_power, cfg[7]);
      chk1(irq, seed[13]);
      apb(0, 12'h01C, 0);
      chk1(r[0], 1'b1);
      apb(0, 12'h008, 0);
      chk(r, exp_hi(vin, cfg[3]));
      apb(0, 12'h00C, 0);
      chk(r, exp_lo(vin, cfg[3]));
      chk1(irq, 1'b0);
    end
    endt(1);
    seed = xs(seed);
    conv(8'h08, seed[9:0]);
    apb(0, 12'h008, 0);
    va = vin;
    vin <= ~va;
    apb(1, 12'h000, 32'h45);
    repeat (400) @(posedge pclk);
    apb(0, 12'h01C, 0);
    chk1(r[1], 1'b1);
    apb(0, 12'h000, 0);
    chk1(r[7], 1'b0);
    apb(0, 12'h00C, 0);
    chk(r, exp_lo(va, 1'b1));
    wait_done();
    apb(0, 12'h008, 0);
    chk(r, exp_hi(~va, 1'b1));
    apb(0, 12'h00C, 0);
    chk(r, exp_lo(~va, 1'b1));
    endt(2);
    apb(1, 12'h010, 32'h3);
    apb(1, 12'h014, 32'hFF);
    apb(1, 12'h004, 32'h30);
    apb(0, 12'h01C, 0);
    vin <= 10'h010;
    apb(0, 12'h008, 0);
    apb(1, 12'h000, 32'h05);
    repeat (300) @(posedge pclk);
    apb(0, 12'h004, 0);
    chk1(r[7], 1'b0);
    apb(0, 12'h01C, 0);
    chk1(r[1], 1'b0);
    apb(0, 12'h00C, 0);
    chk(r, exp_lo(~va, 1'b1));
    apb(1, 12'h004, 0);
    endt(3);
    apb(1, 12'h018, 0);
    for (k = 0; k < 3; k++) begin
      apb(1, 12'h000, 32'h05);
      repeat (8) @(posedge pclk);
      if (k == 0) apb(1, 12'h000, 32'h1F);
      else if (k == 1) apb(1, 12'h004, 0);
      else begin
        stop_req <= 1'b1;
        repeat (4) @(posedge pclk);
        stop_req <= 1'b0;
      end
      apb(0, 12'h004, 0);
      chk1(r[7], 1'b0);
      apb(0, 12'h01C, 0);
      chk1(r[2], 1'b1);
      apb(0, 12'h00C, 0);
      chk(r, exp_lo(~va, 1'b1));
    end
    endt(4);
    apb(1, 12'h018, 32'h01);
    chk1(async_clk_en, 1'b0);
    stop_req <= 1'b1;
    apb(1, 12'h000, 32'h05);
    repeat (4) @(posedge pclk);
    chk1(async_clk_en, 1'b1);
    wait_done();
    stop_req <= 1'b0;
    apb(0, 12'h00C, 0);
    chk(r, exp_lo(vin, 1'b0));
    chk1(async_clk_en, 1'b0);
    endt(5);
    // continuous with a false less-than compare keeps converting
    apb(1, 12'h014, 32'h02);
    apb(1, 12'h004, 32'h20);
    apb(1, 12'h000, 32'h25);
    repeat (300) @(posedge pclk);
    apb(0, 12'h004, 0);
    chk1(r[7], 1'b1);
    apb(0, 12'h000, 0);
    chk1(r[7], 1'b0);
    apb(1, 12'h014, 32'hFF);
    apb(1, 12'h000, 32'h25);
    wait_done();
    apb(0, 12'h00C, 0);
    chk(r, exp_lo(vin, 1'b0));
    apb(1, 12'h000, 32'h1F);
    apb(1, 12'h004, 0);
    endt(6);
    apb(1, 12'h000, 32'h05);
    repeat (24) @(posedge pclk);
    // freeze mid-approximation: the trial code must not move while ce is low
    ce <= 1'b0;
    @(posedge pclk);
    va = dac_code;
    repeat (12) @(posedge pclk);
    chk({22'h0, dac_code}, {22'h0, va});
    chk1(sample_on, 1'b0);
    ce <= 1'b1;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h00C, 0);
    chk(r, 32'h0);
    apb(0, 12'h000, 0);
    chk(r, 32'h1F);
    endt(7);
    summarize();
  end
endmodule

// >>> tb/adcc_analog_model.sv
/*
  Analog channel and comparator seen by the converter.
  Assumes vin is held by the bench for a whole conversion.
*/
`timescale 1ns/1ps
module adcc_analog_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // analog
  input wire logic [9:0] dac_code,
  input wire logic [9:0] vin,
  output logic cmp_in
);
  // registered so the answer lags the trial code by one bus clock, well inside a tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cmp_in <= 1'b0;
    else cmp_in <= vin >= dac_code;
  end
endmodule

// >>> tb/adcc_properties.sv
/*
  Port-level checker of the conversion control block, bound to adcc_top.
  Assumes one pclk domain and presetn active low.
*/
`timescale 1ns/1ps
`include "adcc_params.svh"
module adcc_properties (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // converter side
  input wire logic sample_on,
  input wire logic async_clk_en,
  input wire logic low_power,
  input wire logic stop_req,
  input wire logic irq
);
  logic wr_done, sc1_go, mode_wr, stop_sync, async_sel_q;
  assign wr_done = psel && penable && pready && pwrite;
  assign sc1_go = wr_done && paddr == `ADCC_OFF_SC1 && pwdata[4:0] != `ADCC_CH_OFF;
  assign mode_wr = wr_done && (paddr == `ADCC_OFF_SC2 || paddr == `ADCC_OFF_CFG ||
    paddr == `ADCC_OFF_CV_HI || paddr == `ADCC_OFF_CV_LO);
  // stop aborts only while the bus clock is selected; the enable pin stays low while idle, so mirror the select bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      async_sel_q <= 1'b0;
    end else if (wr_done && paddr == `ADCC_OFF_CFG) begin
      async_sel_q <= pwdata[`ADCC_CFG_ASYNC];
    end
  end
  assign stop_sync = stop_req && !async_sel_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_wait_a: assert property (psel && penable && !pready |=> pready) else $error("pready late");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
  err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  err_data_a: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("error read not zero");
  lp_copy_a: assert property (wr_done && paddr == `ADCC_OFF_CFG |-> ##2 low_power == $past(pwdata[7], 2))
    else $error("low power copy wrong");
  async_rise_a: assert property ($rose(async_clk_en) |-> $past(sc1_go) || $past(sc1_go, 2) || $past(sc1_go, 3))
    else $error("async clock without start");
  abort_idle_a: assert property (mode_wr |-> ##3 !sample_on && !async_clk_en)
    else $error("mode write did not abort");
  stop_abort_a: assert property (stop_sync ##1 stop_sync |=> !sample_on)
    else $error("stop did not abort");
  cover property ($rose(irq));
  cover property (pslverr);
  cover property ($rose(async_clk_en));
endmodule
bind adcc_top adcc_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sample_on(sample_on), .async_clk_en(async_clk_en), .low_power(low_power), .stop_req(stop_req), .irq(irq));
